// >>> twra_pkg.sv
// package: location map, field layout and carrier types for the wide timer byte access path
package twra_pkg;
   // ----------------------------------------------------------------
   // byte location indices on the narrow processor bus
   // ----------------------------------------------------------------
   localparam logic [3:0] LOC_COUNT_LO = 4'h0;    // count_lower_half_location
   localparam logic [3:0] LOC_COUNT_HI = 4'h1;    // count_upper_half_location
   localparam logic [3:0] LOC_CMPA_LO = 4'h2;     // compare a lower half
   localparam logic [3:0] LOC_CMPA_HI = 4'h3;     // compare a upper half
   localparam logic [3:0] LOC_CMPB_LO = 4'h4;     // compare b lower half
   localparam logic [3:0] LOC_CMPB_HI = 4'h5;     // compare b upper half
   localparam logic [3:0] LOC_CAPT_LO = 4'h6;     // capture lower half
   localparam logic [3:0] LOC_CAPT_HI = 4'h7;     // capture_upper_half_location
   localparam logic [3:0] LOC_CTRL2 = 4'h8;       // timer_control_second
   // ----------------------------------------------------------------
   // field layout and reset values
   // ----------------------------------------------------------------
   localparam int CSEL_LSB = 0;                   // clock_source_select position
   localparam int CSEL_W = 3;                     // clock_source_select width
   localparam logic [7:0] CTRL2_RST = 8'h00;      // timer_control_second reset
   localparam logic [7:0] LATCH_RST = 8'h00;      // holding latch reset
   localparam logic [15:0] WIDE_RST = 16'h0000;   // wide register reset
   localparam logic [2:0] CSEL_STOP = 3'h0;       // no clock source: stopped
   localparam logic [2:0] CSEL_EXT_FALL = 3'h6;   // external pin, falling edge
   localparam logic [2:0] CSEL_EXT_RISE = 3'h7;   // external pin, rising edge
   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rd;          // read strobe, one cycle
      logic wr;          // write strobe, one cycle
      logic [3:0] addr;  // byte location
      logic [7:0] wdata; // write byte
   } twra_bus_t;
   typedef struct packed {
      logic load;        // one-cycle commit strobe
      logic [15:0] value;
   } twra_commit_t;
endpackage

// >>> twra_top.sv
// module: byte access path to the wide count, compare and capture registers of one timer
`timescale 1ns/1ps
// How it works
// - wide registers reached as two byte accesses
// - one shared upper-byte holding latch per timer
// - low-byte access performs the sixteen-bit transfer
// - low write loads latch plus byte together
// - count/capture low read returns low, snapshots upper half
// - compare reads bypass the holding latch
// - latch keeps value across successive commits
// - three-bit select picks internal or external clock
// - count/capture upper read returns holding latch
// - select zero stops counting, count stays accessible
// - processor count write beats clear or count
module twra_top
   import twra_pkg::*;
#(
   parameter int PRESC_W = 10 // prescaler width
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic clk_en,
   input wire twra_bus_t bus,
   output logic [7:0] rdata,
   input wire logic [15:0] live_count,
   input wire logic cnt_clear,
   input wire logic cnt_step,
   input wire logic [15:0] cnt_next,
   input wire logic capture_load,
   input wire logic [15:0] capture_in,
   input wire logic ext_clk_pin,
   output twra_commit_t count_commit,
   output logic [15:0] count_value,
   output logic [15:0] compare_a,
   output logic [15:0] compare_b,
   output logic [15:0] capture_value,
   output logic [2:0] clock_source_select,
   output logic timer_tick
);
   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [7:0] latch_ff;         // shared upper-byte holding latch
   logic [15:0] count_ff;        // timer_count_value
   logic [15:0] cmpa_ff;         // compare value a
   logic [15:0] cmpb_ff;         // compare value b
   logic [15:0] capt_ff;         // capture value
   logic [7:0] ctrl2_ff;         // timer_control_second
   logic [7:0] rdata_ff;         // read data register
   twra_commit_t commit_ff;      // count commit strobe to counter
   logic [1:0] ext_sync_ff;      // external clock pin synchroniser
   logic ext_prev_ff;            // previous synchronised level
   logic [PRESC_W-1:0] presc_ff; // internal prescaler
   logic tick_ff;                // timer clock enable
   logic [15:0] wide_word;       // full word formed by a low write
   logic wr_lo_count;            // low-byte write of count
   assign wide_word = {latch_ff, bus.wdata};
   assign wr_lo_count = bus.wr && (bus.addr == LOC_COUNT_LO);
   // ----------------------------------------------------------------
   // holding latch
   // ----------------------------------------------------------------
   // loaded by upper writes and by count/capture low reads only
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         latch_ff <= LATCH_RST;
      end
      else if (clk_en)
      begin
         if (bus.wr && bus.addr[0] && (bus.addr < LOC_CTRL2))
         begin
            latch_ff <= bus.wdata;
         end
         else if (bus.rd && (bus.addr == LOC_COUNT_LO))
         begin
            latch_ff <= live_count[15:8];
         end
         else if (bus.rd && (bus.addr == LOC_CAPT_LO))
         begin
            latch_ff <= capt_ff[15:8];
         end
         // compare reads leave the latch alone, and low writes keep it
      end
   end
   // ----------------------------------------------------------------
   // count register
   // ----------------------------------------------------------------
   // processor commit overrides clear and step from the counter logic
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         count_ff <= WIDE_RST;
      end
      else if (clk_en)
      begin
         if (wr_lo_count)
         begin
            count_ff <= wide_word;
         end
         else if (cnt_clear)
         begin
            count_ff <= WIDE_RST;
         end
         else if (cnt_step && tick_ff && (clock_source_select != CSEL_STOP))
         begin
            count_ff <= cnt_next;
         end
      end
   end
   // ----------------------------------------------------------------
   // compare and capture registers
   // ----------------------------------------------------------------
   // compare values commit only on their own low-byte write, capture also loads on capture_load
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         cmpa_ff <= WIDE_RST;
         cmpb_ff <= WIDE_RST;
         capt_ff <= WIDE_RST;
      end
      else if (clk_en)
      begin
         if (bus.wr && (bus.addr == LOC_CMPA_LO))
         begin
            cmpa_ff <= wide_word;
         end
         if (bus.wr && (bus.addr == LOC_CMPB_LO))
         begin
            cmpb_ff <= wide_word;
         end
         if (bus.wr && (bus.addr == LOC_CAPT_LO))
         begin
            capt_ff <= wide_word;
         end
         else if (capture_load)
         begin
            capt_ff <= capture_in;
         end
      end
   end
   // ----------------------------------------------------------------
   // control register and commit strobe
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ctrl2_ff <= CTRL2_RST;
         commit_ff <= '0;
      end
      else if (clk_en)
      begin
         if (bus.wr && (bus.addr == LOC_CTRL2))
         begin
            ctrl2_ff <= bus.wdata;
         end
         commit_ff.load <= wr_lo_count;
         commit_ff.value <= wide_word;
      end
   end
   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   // upper count/capture reads return the latch, compare reads go direct
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rdata_ff <= 8'h00;
      end
      else if (clk_en && bus.rd)
      begin
         if (bus.addr == LOC_COUNT_LO)
            rdata_ff <= live_count[7:0];
         else if ((bus.addr == LOC_COUNT_HI) || (bus.addr == LOC_CAPT_HI))
            rdata_ff <= latch_ff;
         else if (bus.addr == LOC_CMPA_LO)
            rdata_ff <= cmpa_ff[7:0];
         else if (bus.addr == LOC_CMPA_HI)
            rdata_ff <= cmpa_ff[15:8];
         else if (bus.addr == LOC_CMPB_LO)
            rdata_ff <= cmpb_ff[7:0];
         else if (bus.addr == LOC_CMPB_HI)
            rdata_ff <= cmpb_ff[15:8];
         else if (bus.addr == LOC_CAPT_LO)
            rdata_ff <= capt_ff[7:0];
         else if (bus.addr == LOC_CTRL2)
            rdata_ff <= ctrl2_ff;
         else
            rdata_ff <= 8'h00; // unmapped reads as zero
      end
   end
   // ----------------------------------------------------------------
   // timer clock selection
   // ----------------------------------------------------------------
   // pin sync, then prescaler taps or external edges per select code
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         ext_sync_ff <= 2'b00;
         ext_prev_ff <= 1'b0;
         presc_ff <= '0;
         tick_ff <= 1'b0;
      end
      else if (clk_en)
      begin
         ext_sync_ff <= {ext_sync_ff[0], ext_clk_pin};
         ext_prev_ff <= ext_sync_ff[1];
         presc_ff <= presc_ff + 1'b1;
         case (clock_source_select)
            CSEL_STOP: tick_ff <= 1'b0;
            3'h1: tick_ff <= 1'b1;
            3'h2: tick_ff <= (presc_ff[2:0] == 3'h7);
            3'h3: tick_ff <= (presc_ff[5:0] == 6'h3F);
            3'h4: tick_ff <= (presc_ff[7:0] == 8'hFF);
            3'h5: tick_ff <= (presc_ff[9:0] == 10'h3FF);
            CSEL_EXT_FALL: tick_ff <= ext_prev_ff && !ext_sync_ff[1];
            default: tick_ff <= !ext_prev_ff && ext_sync_ff[1];
         endcase
      end
   end
   assign clock_source_select = ctrl2_ff[CSEL_LSB +: CSEL_W];
   assign timer_tick = tick_ff;
   assign rdata = rdata_ff;
   assign count_commit = commit_ff;
   assign count_value = count_ff;
   assign compare_a = cmpa_ff;
   assign compare_b = cmpb_ff;
   assign capture_value = capt_ff;
   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_low_write_commit;
      @(posedge clk_sys) disable iff (rst)
      (clk_en && bus.wr && bus.addr == LOC_CMPA_LO)
      |=> cmpa_ff == {$past(latch_ff), $past(bus.wdata)};
   endproperty
   a_low_write_commit: assert property (p_low_write_commit)
      else $error("compare a not loaded from latch and byte");
   property p_upper_write_only_latch;
      @(posedge clk_sys) disable iff (rst)
      (clk_en && bus.wr && bus.addr == LOC_CMPB_HI && !capture_load)
      |=> latch_ff == $past(bus.wdata) && $stable(cmpb_ff) && $stable(capt_ff);
   endproperty
   a_upper_write_only_latch: assert property (p_upper_write_only_latch)
      else $error("upper write changed a wide register");
   property p_low_read_snapshot;
      @(posedge clk_sys) disable iff (rst)
      (clk_en && bus.rd && bus.addr == LOC_COUNT_LO)
      |=> latch_ff == $past(live_count[15:8]) && rdata == $past(live_count[7:0]);
   endproperty
   a_low_read_snapshot: assert property (p_low_read_snapshot)
      else $error("count low read did not snapshot upper half");
   property p_compare_read_bypass;
      @(posedge clk_sys) disable iff (rst)
      (clk_en && bus.rd && bus.addr == LOC_CMPA_HI)
      |=> $stable(latch_ff) && rdata == $past(cmpa_ff[15:8]);
   endproperty
   a_compare_read_bypass: assert property (p_compare_read_bypass)
      else $error("compare read used the latch");
   property p_upper_read_latch;
      @(posedge clk_sys) disable iff (rst)
      (clk_en && bus.rd && bus.addr == LOC_CAPT_HI) |=> rdata == $past(latch_ff);
   endproperty
   a_upper_read_latch: assert property (p_upper_read_latch)
      else $error("capture upper read not from latch");
   property p_latch_kept;
      @(posedge clk_sys) disable iff (rst)
      (clk_en && bus.wr && bus.addr == LOC_CMPA_LO) |=> $stable(latch_ff);
   endproperty
   a_latch_kept: assert property (p_latch_kept)
      else $error("latch changed on a low write");
   property p_write_priority;
      @(posedge clk_sys) disable iff (rst)
      (clk_en && wr_lo_count && cnt_clear) |=> count_ff == $past(wide_word);
   endproperty
   a_write_priority: assert property (p_write_priority)
      else $error("count write lost to clear");
   property p_stopped;
      @(posedge clk_sys) disable iff (rst)
      (clock_source_select == CSEL_STOP) [*2] |-> !timer_tick;
   endproperty
   a_stopped: assert property (p_stopped)
      else $error("tick while no clock source selected");
endmodule

// >>> twra_cpu_model.sv
// processor model: byte reads and writes on the narrow timer bus
`timescale 1ns/1ps
module twra_cpu_model
   import twra_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [7:0] rdata,
   output twra_bus_t bus
);
   // ----------------------------------------------------------------
   // byte cycles
   // ----------------------------------------------------------------
   // idle bus: strobes low
   initial bus = '{rd: 1'b0, wr: 1'b0, addr: 4'hF, wdata: 8'h00};
   // one write, held to the taking edge, then address and data go stale
   task automatic wr_byte(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge clk_sys);
      #1;
      bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
   endtask
   // one read, the byte is taken after the taking edge
   task automatic rd_byte(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      bus = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~bus.wdata};
      @(posedge clk_sys);
      #1;
      d = rdata;
      bus = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~bus.wdata};
   endtask
   // ----------------------------------------------------------------
   // wide accesses, nothing may slip in between the two bytes
   // ----------------------------------------------------------------
   // upper half first, then lower half
   task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
      wr_byte(lo + 4'h1, v[15:8]);
      wr_byte(lo, v[7:0]);
   endtask
   // lower half first, then upper half
   task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
      rd_byte(lo, v[7:0]);
      rd_byte(lo + 4'h1, v[15:8]);
   endtask
endmodule

// >>> tb_timer_wide_register_byte_access.sv
// self-checking bench for the wide timer byte access path
`timescale 1ns/1ps
module tb_timer_wide_register_byte_access
   import twra_pkg::*;
;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   twra_bus_t bus;
   logic [7:0] rdata;
   logic [15:0] live_count = 16'h0000;
   logic cnt_clear = 1'b0;
   logic cnt_step = 1'b0;
   logic [15:0] cnt_next = 16'h0000;
   logic capture_load = 1'b0;
   logic [15:0] capture_in = 16'h0000;
   logic ext_clk_pin = 1'b0;
   twra_commit_t count_commit;
   logic [15:0] count_value, compare_a, compare_b, capture_value, v;
   logic [2:0] clock_source_select;
   logic timer_tick;
   logic [7:0] b;
   int miscompares = 0;
   int n_checks = 0;
   int cycles = 0;
   // 200 MHz system clock
   always #2.5 clk_sys = ~clk_sys;
   twra_cpu_model cpu (.clk_sys(clk_sys), .rdata(rdata), .bus(bus));
   twra_top dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en), .bus(bus), .rdata(rdata),
      .live_count(live_count), .cnt_clear(cnt_clear), .cnt_step(cnt_step),
      .cnt_next(cnt_next), .capture_load(capture_load), .capture_in(capture_in),
      .ext_clk_pin(ext_clk_pin), .count_commit(count_commit), .count_value(count_value),
      .compare_a(compare_a), .compare_b(compare_b), .capture_value(capture_value),
      .clock_source_select(clock_source_select), .timer_tick(timer_tick));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // compare and count
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   // verdict and end of run
   task automatic test_done;
      $display("checks %0d, mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         $display("unexpected at %0t: run too long", $time);
         test_done();
      end
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   // reset values and an unmapped read
   task automatic t_reset;
      chk(count_value, WIDE_RST, "count reset");
      chk({13'h0000, clock_source_select}, {13'h0000, CSEL_STOP}, "select reset");
      cpu.rd_byte(4'hF, b);
      chk({8'h00, b}, 16'h0000, "unmapped read");
      $display("t_reset done");
   endtask
   // upper write alone, then the commit
   task automatic t_write;
      cpu.wr_byte(LOC_COUNT_HI, 8'h01);
      chk(count_value, 16'h0000, "upper write alone");
      cpu.wr_byte(LOC_COUNT_LO, 8'hFF);
      chk({15'h0000, count_commit.load}, 16'h0001, "commit strobe");
      chk(count_commit.value, 16'h01FF, "commit word");
      chk(count_value, 16'h01FF, "count word");
      @(posedge clk_sys);
      #1;
      chk({15'h0000, count_commit.load}, 16'h0000, "strobe length");
      $display("t_write done");
   endtask
   // one upper byte shared by several commits
   task automatic t_reuse;
      cpu.wr_byte(LOC_CMPA_HI, 8'hA5);
      chk(compare_a, 16'h0000, "compare upper alone");
      cpu.wr_byte(LOC_CMPA_LO, 8'h11);
      cpu.wr_byte(LOC_CMPB_LO, 8'h22);
      cpu.wr_byte(LOC_CAPT_LO, 8'h33);
      chk(compare_a, 16'hA511, "compare a");
      chk(compare_b, 16'hA522, "compare b");
      chk(capture_value, 16'hA533, "capture");
      chk(count_value, 16'h01FF, "count untouched");
      $display("t_reuse done");
   endtask
   // snapshots, latch reads and compare bypass
   task automatic t_read;
      live_count = 16'hBEEF;
      cpu.rd_byte(LOC_COUNT_LO, b);
      chk({8'h00, b}, 16'h00EF, "count low");
      live_count = 16'h1234;
      cpu.rd_byte(LOC_COUNT_HI, b);
      chk({8'h00, b}, 16'h00BE, "count high");
      cpu.rd_byte(LOC_CMPA_LO, b);
      chk({8'h00, b}, 16'h0011, "compare low");
      cpu.rd_byte(LOC_CMPA_HI, b);
      chk({8'h00, b}, 16'h00A5, "compare a high");
      cpu.rd_byte(LOC_CMPB_HI, b);
      chk({8'h00, b}, 16'h00A5, "compare high direct");
      cpu.rd_byte(LOC_COUNT_HI, b);
      chk({8'h00, b}, 16'h00BE, "latch kept");
      capture_in = 16'h0F0F;
      capture_load = 1'b1;
      @(posedge clk_sys);
      #1;
      capture_load = 1'b0;
      cpu.rd16(LOC_CAPT_LO, v);
      chk(v, 16'h0F0F, "capture pair");
      // an intruding upper write spoils the pending snapshot
      cpu.rd_byte(LOC_CAPT_LO, b);
      cpu.wr_byte(LOC_CMPA_HI, 8'h5A);
      cpu.rd_byte(LOC_CAPT_HI, b);
      chk({8'h00, b}, 16'h005A, "shared latch");
      $display("t_read done");
   endtask
   // clock enable low freezes compare b and the latch
   task automatic t_freeze;
      clk_en = 1'b0;
      cpu.wr16(LOC_CMPB_LO, 16'h7788);
      chk(compare_b, 16'hA522, "frozen compare");
      clk_en = 1'b1;
      cpu.rd_byte(LOC_COUNT_HI, b);
      chk({8'h00, b}, 16'h005A, "frozen latch");
      cpu.wr16(LOC_CMPB_LO, 16'h7788);
      chk(compare_b, 16'h7788, "compare b pair");
      $display("t_freeze done");
   endtask
   // processor write against clear and step
   task automatic t_priority;
      cpu.wr_byte(LOC_CTRL2, 8'h01);
      cnt_next = 16'h4444;
      cnt_step = 1'b1;
      cnt_clear = 1'b1;
      cpu.wr16(LOC_COUNT_LO, 16'h2345);
      chk(count_value, 16'h2345, "write wins");
      cnt_clear = 1'b0;
      cnt_step = 1'b0;
      $display("t_priority done");
   endtask
   // stopped timer, then every select code
   task automatic t_select;
      int n;
      int exp_ticks [8] = '{0, 1024, 128, 16, 4, 1, 3, 4};
      cpu.wr_byte(LOC_CTRL2, {5'h00, CSEL_STOP});
      cnt_step = 1'b1;
      repeat (20) @(posedge clk_sys);
      #1;
      chk(count_value, 16'h2345, "stopped");
      cpu.wr16(LOC_COUNT_LO, 16'h0102);
      chk(count_value, 16'h0102, "write while stopped");
      cnt_step = 1'b0;
      for (int i = 1; i < 8; i++)
      begin
         n = 0;
         cpu.wr_byte(LOC_CTRL2, 8'(i));
         chk({13'h0000, clock_source_select}, 16'(i), "select field");
         repeat (8) @(posedge clk_sys);
         for (int c = 0; c < 1024; c++)
         begin
            @(posedge clk_sys);
            #1;
            if (timer_tick === 1'b1)
               n++;
            // external pin toggles every 16 cycles early in the window
            if (i > 5 && c < 128)
               ext_clk_pin = c[4];
         end
         chk(16'(n), 16'(exp_ticks[i]), "tick count");
      end
      $display("t_select done");
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      t_reset();
      t_write();
      t_reuse();
      t_read();
      t_freeze();
      t_priority();
      t_select();
      test_done();
   end
endmodule
